// ==== core/dsc_regs.svh ====
// Constants of the serial control port: frame layout, selects, resets.
// Assumes inclusion by bare name from the port's design files.
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
`define DSC_FRAME_BITS 24
`define DSC_CNT_BITS 5
`define DSC_SYNC_STAGES 2
`define DSC_SEL_CFG 5'h00
`define DSC_SEL_SPI_MODE 5'h06
`define DSC_CFG_SDO_DIS_POS 6
`define DSC_CFG_CS_WAKE_POS 4
`define DSC_MODE_SLEEP_POS 15
`define DSC_WAKE_MAX_EDGES 5'h01
`define DSC_SDO_DIS_RST 1'b0
`define DSC_CS_WAKE_RST 1'b0
`define DSC_RD_PAD 8'h00
`define DSC_PIN_RST 3'h7
`endif

// ==== core/dsc_pkg.sv ====
// Types of the serial control port: frame fields, register write, mode.
// Assumes nothing beyond a SystemVerilog compiler.
package dsc_pkg;
    typedef struct packed {
        logic rw;
        logic [1:0] spare;
        logic [4:0] sel;
        logic [15:0] data;
    } dsc_frame_t;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [15:0] data;
    } dsc_wr_t;

    typedef enum logic [1:0] {
        DSC_NORMAL = 2'b01,
        DSC_SLEEP = 2'b10
    } dsc_mode_t;
endpackage

// ==== core/dsc_sync.sv ====
// Two-stage synchroniser for a group of pin levels.
// Assumes asynchronous pin inputs and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dsc_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule
`default_nettype wire

// ==== core/dsc_shift.sv ====
// Link-side shift register and frame bit counter, clocked by the serial clock.
// Assumes chip select meets the host's setup and hold to the serial clock.
`timescale 1ns/1ps
`default_nettype none
module dsc_shift #(
    parameter int W = 24,
    parameter int CW = 5
) (
    // Link clock and controls
    input wire logic sclk,
    input wire logic rst_b,
    input wire logic cnt_clr,
    input wire logic cs_n,
    input wire logic hold,
    // Data
    input wire logic sdi,
    input wire logic [W-1:0] preload,
    output logic [W-1:0] shreg,
    output logic [CW-1:0] count,
    output logic bypass
);
    localparam logic [CW-1:0] SAT = CW'(W + 1);
    logic frame_idle;
    logic cnt_rst;
    logic armed_q;
    logic [W-1:0] src;
    logic [W-1:0] shreg_q;
    logic [W-1:0] shreg_d;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic byp_q;
    logic byp_d;

    assign frame_idle = cs_n | ~rst_b;
    assign cnt_rst = cnt_clr | ~rst_b;

    always_comb begin
        src = armed_q ? preload : shreg_q;
        shreg_d = shreg_q;
        count_d = count_q;
        byp_d = byp_q;
        if (!cs_n) begin
            byp_d = sdi;
            if (!hold) begin
                shreg_d = {src[W-2:0], sdi};
            end
            if (count_q != SAT) begin
                count_d = count_q + 1'b1;
            end
        end
    end

    // First edge of a frame takes the preload word instead of old contents
    always_ff @(negedge sclk or posedge frame_idle) begin
        if (frame_idle) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            shreg_q <= '0;
            byp_q <= 1'b0;
        end else begin
            shreg_q <= shreg_d;
            byp_q <= byp_d;
        end
    end

    // Cleared between frames by the decoder, while the link clock is ignored
    always_ff @(negedge sclk or posedge cnt_rst) begin
        if (cnt_rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign shreg = shreg_q;
    assign count = count_q;
    assign bypass = byp_q;
endmodule
`default_nettype wire

// ==== core/dsc_port.sv ====
// Serial control port of an octal DAC: frame capture, decode, daisy chain,
// sleep bypass, wake-up and pipelined read-back.
// Assumes the register file answers rd_data combinationally from rd_addr.
//
// Contract
// - 24-bit frames, most significant bit first.
// - Frame: rw flag, spare, select, data.
// - Sample input on falling clock, select low.
// - Select high: ignore clock, output high impedance.
// - Select rising edge decodes and writes register.
// - Under 24 edges: frame discarded entirely.
// - Over 24 edges: last 24 bits used.
// - Output driven only while sdo_disable is zero.
// - Normal chain: 24-stage delay to output.
// - Output changes on rising clock edges.
// - Sleep: direct passthrough, no commands accepted; the code delays the data one clock through a falling-edge register.
// - Wake-up pin low clears sleep.
// - Select wake with at most one edge.
// - Read frame selects register, data ignored.
// - Next frame shifts out selected register.
// - Load pin low updates all outputs.
// - Bit 23 rw, 20..16 select, 15..0 data.
// - Spare bits ignored, read back zero.
// - Reset low disables port, output high impedance.
// - Port stays live during device power-down.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.svh"
module dsc_port #(
    parameter int FRAME_BITS = `DSC_FRAME_BITS,
    parameter int CNT_BITS = `DSC_CNT_BITS
) (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic sclk,
    // Serial pins
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    // Device pins
    input wire logic wakeup_n,
    input wire logic load_outputs_n,
    // Register side
    output dsc_pkg::dsc_wr_t reg_wr,
    output logic [4:0] rd_addr,
    input wire logic [15:0] rd_data,
    // Status
    output dsc_pkg::dsc_mode_t port_mode,
    output logic sdo_disable,
    output logic cs_wake_enable,
    output logic frame_drop,
    output logic load_outputs
);
    import dsc_pkg::*;

    localparam logic [CNT_BITS-1:0] FULL = CNT_BITS'(FRAME_BITS);

    logic cs_s;
    logic wake_s;
    logic ld_s;
    logic [FRAME_BITS-1:0] shreg;
    logic [CNT_BITS-1:0] count;
    logic bypass;
    dsc_frame_t frame;
    logic cs_rise;
    logic frame_ok;
    logic asleep;
    logic frame_idle;
    logic [15:0] mode_word;

    // Reference-domain state
    dsc_mode_t mode_q;
    dsc_mode_t mode_d;
    logic sdo_dis_q;
    logic sdo_dis_d;
    logic wake_en_q;
    logic wake_en_d;
    dsc_wr_t wr_q;
    dsc_wr_t wr_d;
    logic [4:0] rd_addr_q;
    logic [4:0] rd_addr_d;
    logic rd_pend_q;
    logic rd_pend_d;
    logic [FRAME_BITS-1:0] rb_word_q;
    logic [FRAME_BITS-1:0] rb_word_d;
    logic drop_q;
    logic drop_d;
    logic load_q;
    logic load_d;
    logic cnt_clr_q;
    logic cnt_clr_d;
    logic cs_prev_q;
    logic ld_prev_q;

    // Link-domain output state
    logic lead_q;
    logic sdo_q;
    logic sdo_d;
    logic oe_n_q;
    logic oe_n_d;

    dsc_sync #(
        .W(3),
        .RST_VAL(`DSC_PIN_RST)
    ) u_sync (
        .clk(ref_clk),
        .rst_b(rst_b),
        .din({cs_n, wakeup_n, load_outputs_n}),
        .dout({cs_s, wake_s, ld_s})
    );

    // Read-back word is quasi-static: it changes only while select is high, so the link
    // clock never samples it in motion; mode also changes mid-frame when the wake-up pin clears sleep.
    dsc_shift #(
        .W(FRAME_BITS),
        .CW(CNT_BITS)
    ) u_shift (
        .sclk(sclk),
        .rst_b(rst_b),
        .cnt_clr(cnt_clr_q),
        .cs_n(cs_n),
        .hold(asleep),
        .sdi(sdi),
        .preload(rb_word_q),
        .shreg(shreg),
        .count(count),
        .bypass(bypass)
    );

    assign frame = dsc_frame_t'(shreg);
    assign cs_rise = cs_s & ~cs_prev_q;
    assign frame_ok = (count >= FULL);
    assign asleep = (mode_q == DSC_SLEEP);
    assign frame_idle = cs_n | ~rst_b;

    // Decode at the select rising edge; the shifter is idle then
    always_comb begin
        mode_word = '0;
        mode_word[`DSC_MODE_SLEEP_POS] = asleep;
        mode_d = mode_q;
        sdo_dis_d = sdo_dis_q;
        wake_en_d = wake_en_q;
        wr_d = wr_q;
        wr_d.valid = 1'b0;
        rd_addr_d = rd_addr_q;
        rd_pend_d = 1'b0;
        rb_word_d = rb_word_q;
        drop_d = 1'b0;
        load_d = ld_prev_q & ~ld_s;
        cnt_clr_d = cs_rise;
        if (rd_pend_q) begin
            // Selected register's data plus zero padding in the upper byte
            rb_word_d = {`DSC_RD_PAD,
                         (rd_addr_q == `DSC_SEL_SPI_MODE) ? mode_word : rd_data};
        end
        if (cs_rise) begin
            if (asleep) begin
                if (wake_en_q && count <= `DSC_WAKE_MAX_EDGES) begin
                    mode_d = DSC_NORMAL;
                end
            end else if (!frame_ok) begin
                drop_d = 1'b1;
            end else if (frame.rw) begin
                rd_addr_d = frame.sel;
                rd_pend_d = 1'b1;
            end else begin
                wr_d.valid = 1'b1;
                wr_d.addr = frame.sel;
                wr_d.data = frame.data;
                rb_word_d = '0;
                if (frame.sel == `DSC_SEL_CFG) begin
                    sdo_dis_d = frame.data[`DSC_CFG_SDO_DIS_POS];
                    wake_en_d = frame.data[`DSC_CFG_CS_WAKE_POS];
                end
                if (frame.sel == `DSC_SEL_SPI_MODE) begin
                    mode_d = frame.data[`DSC_MODE_SLEEP_POS] ? DSC_SLEEP : DSC_NORMAL;
                end
            end
        end
        if (!wake_s) begin
            mode_d = DSC_NORMAL;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= DSC_NORMAL;
            sdo_dis_q <= `DSC_SDO_DIS_RST;
            wake_en_q <= `DSC_CS_WAKE_RST;
            wr_q <= '0;
            rd_addr_q <= '0;
            rd_pend_q <= 1'b0;
            rb_word_q <= '0;
            drop_q <= 1'b0;
            load_q <= 1'b0;
            cnt_clr_q <= 1'b0;
            cs_prev_q <= 1'b1;
            ld_prev_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            sdo_dis_q <= sdo_dis_d;
            wake_en_q <= wake_en_d;
            wr_q <= wr_d;
            rd_addr_q <= rd_addr_d;
            rd_pend_q <= rd_pend_d;
            rb_word_q <= rb_word_d;
            drop_q <= drop_d;
            load_q <= load_d;
            cnt_clr_q <= cnt_clr_d;
            cs_prev_q <= cs_s;
            ld_prev_q <= ld_s;
        end
    end

    // Set between frames, cleared by the first falling link clock edge
    always_ff @(negedge sclk or posedge frame_idle) begin
        if (frame_idle) begin
            lead_q <= 1'b1;
        end else begin
            lead_q <= 1'b0;
        end
    end

    // Serial output launched on rising link clock edges; outside sleep the first one of a frame
    // shows the read-back word's top bit, as the shifter still holds the last frame
    always_comb begin
        sdo_d = asleep ? bypass : shreg[FRAME_BITS-1];
        if (!asleep && lead_q) begin
            sdo_d = rb_word_q[FRAME_BITS-1];
        end
        oe_n_d = sdo_dis_q;
    end

    always_ff @(posedge sclk or posedge frame_idle) begin
        if (frame_idle) begin
            sdo_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            sdo_q <= sdo_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign sdo = sdo_q;
    assign sdo_oe_n = oe_n_q;
    assign reg_wr = wr_q;
    assign rd_addr = rd_addr_q;
    assign port_mode = mode_q;
    assign sdo_disable = sdo_dis_q;
    assign cs_wake_enable = wake_en_q;
    assign frame_drop = drop_q;
    assign load_outputs = load_q;

    wr_needs_frame_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wr_q.valid |-> $past(cs_rise) && $past(frame_ok) && !$past(frame.rw))
        else $error("write issued without a complete frame");

    short_frame_drop_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        cs_rise && !asleep && count < FULL |=> !wr_q.valid && drop_q)
        else $error("short frame was not discarded");

    field_map_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        cs_rise && !asleep && frame_ok && !frame.rw
        |=> wr_q.addr == $past(frame.sel) && wr_q.data == $past(frame.data))
        else $error("write fields taken from wrong frame bits");

    read_pipe_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        cs_rise && !asleep && frame_ok && frame.rw && frame.sel != `DSC_SEL_SPI_MODE
        ##1 !cs_rise
        |-> rd_addr_q == $past(frame.sel) && !wr_q.valid
            ##1 rb_word_q[15:0] == $past(rd_data) && rb_word_q[23:16] == '0)
        else $error("read-back word not loaded from selected register");

    wake_pin_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !wake_s |=> mode_q == DSC_NORMAL)
        else $error("wake-up pin did not clear sleep");

    cs_wake_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        cs_rise && asleep && wake_en_q && count <= `DSC_WAKE_MAX_EDGES
        |=> mode_q == DSC_NORMAL)
        else $error("select edge did not wake the port");

    sleep_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        cs_rise && asleep && count > `DSC_WAKE_MAX_EDGES && wake_s
        |=> mode_q == DSC_SLEEP && !wr_q.valid && !rd_pend_q)
        else $error("sleeping port accepted a frame");

    load_pulse_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        $fell(ld_s) |=> load_q ##1 !load_q)
        else $error("load pin did not give one update pulse");

    sdo_off_a: assert property (
        @(posedge sclk) disable iff (frame_idle)
        sdo_dis_q ##1 sdo_dis_q |-> oe_n_q)
        else $error("serial output driven while disabled");

    chain_delay_a: assert property (
        @(posedge sclk) disable iff (frame_idle)
        !asleep && !lead_q ##1 !asleep |-> sdo_q == $past(shreg[FRAME_BITS-1]))
        else $error("serial output not taken from shift register tail");

    lead_bit_a: assert property (
        @(posedge sclk) disable iff (frame_idle)
        !asleep && lead_q ##1 !asleep |-> sdo_q == $past(rb_word_q[FRAME_BITS-1]))
        else $error("first serial output bit not taken from read-back word");
endmodule
`default_nettype wire

// ==== test/dsc_host.sv ====
// Host model of the serial control port: drives chip select, link clock and data.
// Assumes the bench calls xfer with chip select idle and the port out of reset.
`timescale 1ns/1ps
`default_nettype none
module dsc_host (
    // Serial pins toward the port
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    // Return path
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    logic last_sdo = 1'b0;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
    end

    // Link clock runs only inside a frame, 80 ns period
    task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rx,
                        output logic oe);
        logic line;
        rx = '0;
        oe = 1'b0;
        #7;
        cs_n = 1'b0;
        #40;
        for (int j = n - 1; j >= 0; j--) begin
            sclk = 1'b1;
            sdi = w[j];
            #40;
            // Released output shows the inverse of its last driven level
            line = sdo_oe_n ? ~last_sdo : sdo;
            if (!sdo_oe_n) begin
                last_sdo = sdo;
                oe = 1'b1;
            end
            rx = {rx[46:0], line};
            sclk = 1'b0;
            #40;
        end
        cs_n = 1'b1;
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire

// ==== test/dac_serial_port_daisy_chain_tb.sv ====
// Self-checking bench of the serial control port with a host model on the link.
// Assumes the design and host model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_port_daisy_chain_tb;
    import dsc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic sclk, cs_n, sdi, sdo, sdo_oe_n, any_oe;
    logic wakeup_n = 1'b1;
    logic load_outputs_n = 1'b1;
    logic [15:0] rd_data;
    logic [4:0] rd_addr;
    dsc_wr_t reg_wr, last_wr;
    dsc_mode_t port_mode;
    logic sdo_disable, cs_wake_enable, frame_drop, load_outputs;
    int num_errors = 0;
    int total_checks = 0;
    int wr_cnt = 0;
    int drop_cnt = 0;
    logic [31:0] seed = 32'hefc0dd0a;
    logic [47:0] rx, fw;

    always #5 ref_clk = ~ref_clk;

    // Register file stand-in: content is a fixed pattern of the select
    assign rd_data = rb_exp(rd_addr);

    dsc_port dut (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n), .wakeup_n(wakeup_n), .load_outputs_n(load_outputs_n),
        .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data), .port_mode(port_mode),
        .sdo_disable(sdo_disable), .cs_wake_enable(cs_wake_enable), .frame_drop(frame_drop),
        .load_outputs(load_outputs));

    dsc_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

    always @(posedge ref_clk) begin
        if (reg_wr.valid === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_wr <= reg_wr;
        end
        if (frame_drop === 1'b1) begin
            drop_cnt <= drop_cnt + 1;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction

    function automatic logic [15:0] rb_exp(input logic [4:0] s);
        return {3'h5, s, 8'h3c};
    endfunction

    function automatic logic [47:0] mk(input logic rw, input logic [1:0] sp,
                                       input logic [4:0] s, input logic [15:0] d);
        dsc_frame_t f;
        f = '{rw: rw, spare: sp, sel: s, data: d};
        return {24'h000000, f};
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Chip select then stays high well over the decode and clear time
    task automatic frame(input logic [47:0] w, input int n);
        fw = w;
        host.xfer(w, n, rx, any_oe);
        repeat (10) @(negedge ref_clk);
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        logic [15:0] d;
        logic [4:0] s;
        int w0;
        int d0;
        int k;
        repeat (6) @(posedge ref_clk);
        check(48'(sdo_oe_n), 48'h1);
        @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge ref_clk);
        check(48'(port_mode), 48'(DSC_NORMAL));
        check(48'(sdo_disable), 48'h0);
        check(48'(cs_wake_enable), 48'h0);
        // Random writes to channel selects with random spare bits
        for (k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            s = {2'b01, seed[2:0]};
            d = seed[31:16];
            w0 = wr_cnt;
            frame(mk(1'b0, seed[4:3], s, d), 24);
            check(48'(wr_cnt - w0), 48'h1);
            check(48'({last_wr.addr, last_wr.data}), 48'({s, d}));
        end
        // Short frame is dropped, long frame keeps its last 24 bits
        w0 = wr_cnt;
        d0 = drop_cnt;
        frame(mk(1'b0, 2'b00, 5'h09, 16'h1234), 23);
        check(48'(wr_cnt - w0), 48'h0);
        check(48'(drop_cnt - d0), 48'h1);
        frame({18'h3ffff, 6'h2a, 24'(mk(1'b0, 2'b00, 5'h0c, 16'hbeef))}, 30);
        check(48'({last_wr.addr, last_wr.data}), 48'({5'h0c, 16'hbeef}));
        // Two words in one frame: the first ripples out 24 clocks later
        seed = lfsr(seed);
        frame({24'(mk(1'b0, 2'b00, 5'h09, seed[15:0])),
               24'(mk(1'b0, 2'b00, 5'h0a, seed[31:16]))}, 48);
        check(rx[23:0], fw[47:24]);
        check(48'(last_wr.addr), 48'h0a);
        check(48'(sdo_oe_n), 48'h1);
        // Two reads and a write frame to select 5: the second and third frames return the previous selection
        w0 = wr_cnt;
        frame(mk(1'b1, 2'b11, 5'h0b, 16'hffff), 24);
        check(48'(wr_cnt - w0), 48'h0);
        check(48'(rd_addr), 48'h0b);
        frame(mk(1'b1, 2'b00, 5'h06, 16'h0000), 24);
        check(48'(rd_addr), 48'h06);
        check(rx[23:0], 48'({8'h00, rb_exp(5'h0b)}));
        frame(mk(1'b0, 2'b00, 5'h05, 16'h0000), 24);
        check(rx[23:0], 48'h0);
        // Output disabled: never driven during a frame
        frame(mk(1'b0, 2'b00, 5'h00, 16'h0040), 24);
        check(48'(sdo_disable), 48'h1);
        frame(mk(1'b0, 2'b00, 5'h08, 16'h5555), 24);
        check(48'(any_oe), 48'h0);
        frame(mk(1'b0, 2'b00, 5'h00, 16'h0010), 24);
        check(48'({sdo_disable, cs_wake_enable}), 48'h1);
        // Sleep: one-clock passthrough, no commands taken
        frame(mk(1'b0, 2'b00, 5'h06, 16'h8000), 24);
        check(48'(port_mode), 48'(DSC_SLEEP));
        seed = lfsr(seed);
        w0 = wr_cnt;
        frame(mk(1'b0, 2'b00, 5'h08, seed[15:0]), 24);
        check(48'(rx[22:0]), 48'(fw[23:1]));
        check(48'(wr_cnt - w0), 48'h0);
        d0 = drop_cnt;
        frame(48'h0, 2);
        check(48'(port_mode), 48'(DSC_SLEEP));
        check(48'(drop_cnt - d0), 48'h0);
        frame(48'h0, 1);
        check(48'(port_mode), 48'(DSC_NORMAL));
        // Wake-up pin
        frame(mk(1'b0, 2'b00, 5'h06, 16'h8000), 24);
        check(48'(port_mode), 48'(DSC_SLEEP));
        wakeup_n = 1'b0;
        for (k = 0; k < 10 && port_mode !== DSC_NORMAL; k++) @(negedge ref_clk);
        check(48'(port_mode), 48'(DSC_NORMAL));
        wakeup_n = 1'b1;
        // Load pin gives one pulse
        @(negedge ref_clk);
        load_outputs_n = 1'b0;
        for (k = 0; k < 10 && load_outputs !== 1'b1; k++) @(negedge ref_clk);
        check(48'(load_outputs), 48'h1);
        @(negedge ref_clk);
        check(48'(load_outputs), 48'h0);
        load_outputs_n = 1'b1;
        // Reset in mid-run returns the configuration to its defaults
        rst_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        check(48'({cs_wake_enable, port_mode}), 48'({1'b0, DSC_NORMAL}));
        check(48'(sdo_oe_n), 48'h1);
        rst_b = 1'b1;
        repeat (3) @(negedge ref_clk);
        seed = lfsr(seed);
        w0 = wr_cnt;
        frame(mk(1'b0, 2'b00, 5'h0f, seed[15:0]), 24);
        check(48'(wr_cnt - w0), 48'h1);
        check(48'({last_wr.addr, last_wr.data}), 48'({5'h0f, seed[15:0]}));
        repeat (4) @(negedge ref_clk);
        finish_test();
    end
endmodule
`default_nettype wire
